// >>> bench/pcem_crossbar_tb_top.sv
// Self-checking bench for the routing enables and port match block.
// Assumes registers answer on the paged special function register port.
`timescale 1ns/1ps
module pcem_crossbar_tb_top;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  pcem_pkg::pcem_sfr_req_t sfr_req = '0;
  logic sfr_hit, sfr_rvalid, timer0_ext_in, timer1_ext_in;
  logic array_count_in, port_output_allow;
  logic mismatch_level, mismatch_irq, mismatch_wake;
  logic [7:0] sfr_rdata;
  logic [3:0] second_spi_pin_en;
  logic [8:0] func_pin_valid;
  logic [8:0][4:0] func_pin_idx;
  logic four_wire = 1'b0;
  logic [22:0] skip = '0, claimed = '0, analog = 23'h00f0f0;
  logic [22:0] pin_drive_en = '1, drive_val = '0;
  logic [22:0] port_pin_in, weak_pullup_en;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;

  pcem_crossbar pcem_crossbar_inst (.clk(clk), .resetn(resetn),
    .sfr_req(sfr_req), .sfr_hit(sfr_hit), .sfr_rdata(sfr_rdata),
    .sfr_rvalid(sfr_rvalid), .second_spi_four_wire(four_wire),
    .pin_skip_bits(skip), .pins_claimed_above(claimed),
    .pin_analog_mode(analog), .port_pin_in(port_pin_in),
    .second_spi_pin_en(second_spi_pin_en),
    .func_pin_valid(func_pin_valid), .func_pin_idx(func_pin_idx),
    .timer0_ext_in(timer0_ext_in), .timer1_ext_in(timer1_ext_in),
    .array_count_in(array_count_in),
    .port_output_allow(port_output_allow),
    .weak_pullup_en(weak_pullup_en), .mismatch_level(mismatch_level),
    .mismatch_irq(mismatch_irq), .mismatch_wake(mismatch_wake));
  pcem_pin_model pcem_pin_model_inst (.clk(clk), .drive_en(pin_drive_en),
    .drive_val(drive_val), .weak_pullup_en(weak_pullup_en),
    .port_pin_in(port_pin_in));

  // Clock at 100 MHz
  initial begin
    forever #5 clk = ~clk;
  end
  // Hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      summarize();
    end
  end

  task summarize;
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task chk(string what, logic [44:0] exp, logic [44:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task cyc(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task wr(logic [7:0] pg, logic [7:0] a, logic [7:0] d);
    sfr_req = '{page: pg, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
    cyc(1);
    sfr_req = '0;
    cyc(1);
  endtask : wr

  task rdchk(logic [7:0] pg, logic [7:0] a, logic [7:0] e, logic hit);
    sfr_req = '{page: pg, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
    #1;
    chk("hit", hit, sfr_hit);
    cyc(1);
    sfr_req = '0;
    chk("rvalid", 1'b1, sfr_rvalid);
    chk("rdata", e, sfr_rdata);
    cyc(1);
  endtask : rdchk

  // Reset values and page map
  task t_reset;
    rdchk(8'h00, 8'hc7, 8'h00, 1'b1);
    rdchk(8'h00, 8'hd7, 8'hff, 1'b1);
    rdchk(8'h00, 8'hbf, 8'h00, 1'b1);
    rdchk(8'h00, 8'hcf, 8'hff, 1'b1);
    rdchk(8'h00, 8'he2, 8'h00, 1'b1);
    rdchk(8'h0f, 8'he3, 8'h00, 1'b1);
    rdchk(8'h0f, 8'he2, 8'h00, 1'b0);
    rdchk(8'h00, 8'h55, 8'h00, 1'b0);
  endtask : t_reset

  // Read-only bits, pages, matrix off, pullups
  task t_access;
    wr(8'h00, 8'he2, 8'hff);
    rdchk(8'h00, 8'he2, 8'h7f, 1'b1);
    wr(8'h0f, 8'he3, 8'hff);
    rdchk(8'h00, 8'he3, 8'hc0, 1'b1);
    wr(8'h0f, 8'he2, 8'h00);
    rdchk(8'h00, 8'he2, 8'h7f, 1'b1);
    wr(8'h00, 8'he3, 8'h00);
    cyc(3);
    chk("out_allow", 1'b0, port_output_allow);
    chk("spi_en", 4'h0, second_spi_pin_en);
    chk("valid", 9'h000, func_pin_valid);
    chk("pullup", analog ^ 23'h7fffff, weak_pullup_en);
    wr(8'h00, 8'he3, 8'h80);
    cyc(3);
    chk("pullup", 23'h0, weak_pullup_en);
  endtask : t_access

  // Fixed second SPI pins, select only in four-wire mode
  task t_spi;
    wr(8'h00, 8'he3, 8'h40);
    wr(8'h00, 8'he2, 8'h40);
    four_wire = 1'b1;
    cyc(3);
    chk("out_allow", 1'b1, port_output_allow);
    chk("spi_en", 4'hf, second_spi_pin_en);
    four_wire = 1'b0;
    cyc(3);
    chk("spi_en", 4'h7, second_spi_pin_en);
    wr(8'h00, 8'he2, 8'h00);
    cyc(3);
    chk("spi_en", 4'h0, second_spi_pin_en);
  endtask : t_spi

  // Timer inputs take the lowest free pins past a claimed one
  task t_timer;
    claimed = 23'h1;
    wr(8'h00, 8'he2, 8'h30);
    drive_val = 23'h2;
    cyc(3);
    chk("valid", 9'h180, func_pin_valid);
    chk("t0_idx", 5'h01, func_pin_idx[7]);
    chk("t1_idx", 5'h02, func_pin_idx[8]);
    chk("t0_in", 1'b1, timer0_ext_in);
    chk("t1_in", 1'b0, timer1_ext_in);
    drive_val = 23'h4;
    cyc(3);
    chk("t0_in", 1'b0, timer0_ext_in);
    chk("t1_in", 1'b1, timer1_ext_in);
    wr(8'h00, 8'he2, 8'h00);
    cyc(3);
    chk("valid", 9'h000, func_pin_valid);
    chk("t1_in", 1'b0, timer1_ext_in);
    claimed = '0;
  endtask : t_timer

  // Every module pin count with the count input and pin 0 skipped
  task t_count;
    logic [8:0] ev;
    logic [4:0] ei;
    skip = 23'h1;
    for (int n = 0; n < 8; n++) begin
      ev = (n == 7) ? 9'h040 : (9'h040 | 9'((1 << n) - 1));
      ei = (n == 7) ? 5'h01 : 5'(n + 1);
      wr(8'h00, 8'he2, 8'h08 | 8'(n));
      drive_val = 23'(1) << ei;
      cyc(3);
      chk("valid", ev, func_pin_valid);
      chk("cnt_idx", ei, func_pin_idx[6]);
      chk("cnt_in", 1'b1, array_count_in);
    end
    wr(8'h00, 8'he2, 8'h00);
    skip = '0;
  endtask : t_count

  // Masked compare on both ports while pin 0 is routed
  task t_match;
    wr(8'h00, 8'he2, 8'h10);
    drive_val = 23'h000035;
    cyc(4);
    chk("mism", 1'b0, mismatch_level);
    wr(8'h00, 8'hc7, 8'h0f);
    wr(8'h00, 8'hd7, 8'h05);
    cyc(3);
    chk("mism", 1'b0, mismatch_level);
    drive_val = 23'h0000f5;
    cyc(4);
    chk("mism", 1'b0, mismatch_level);
    drive_val = 23'h0000f4;
    cyc(4);
    chk("mism", 1'b1, mismatch_level);
    chk("irq", 1'b1, mismatch_irq);
    chk("wake", 1'b1, mismatch_wake);
    wr(8'h00, 8'hd7, 8'h04);
    cyc(3);
    chk("mism", 1'b0, mismatch_level);
    wr(8'h00, 8'hbf, 8'h01);
    cyc(3);
    chk("mism", 1'b1, mismatch_level);
    wr(8'h00, 8'hcf, 8'hfe);
    cyc(3);
    chk("mism", 1'b0, mismatch_level);
  endtask : t_match

  // Main sequence, with a second reset in mid-run
  initial begin
    repeat (6) @(posedge clk);
    #1;
    resetn = 1'b1;
    cyc(1);
    t_reset();
    t_access();
    t_spi();
    t_timer();
    t_count();
    t_match();
    resetn = 1'b0;
    cyc(2);
    resetn = 1'b1;
    cyc(1);
    t_reset();
    summarize();
  end
endmodule : pcem_crossbar_tb_top

// >>> bench/pcem_pin_model.sv
// Pad model for the port pins seen by the routing and match block.
// Assumes the bench chooses which pins are driven and to what level.
`timescale 1ns/1ps
module pcem_pin_model #(
  parameter int NP = pcem_pkg::PCEM_PINS
) (
  input wire logic clk,
  input wire logic [NP-1:0] drive_en,
  input wire logic [NP-1:0] drive_val,
  input wire logic [NP-1:0] weak_pullup_en,
  output logic [NP-1:0] port_pin_in
);
  logic [NP-1:0] float_reg = '0;
  // Floating pins without pullup wander every cycle
  always_ff @(posedge clk) begin
    float_reg <= ~float_reg;
  end
  // Pad level whatever the routing; released pins pulled or floating
  assign port_pin_in = (drive_en & drive_val)
    | (~drive_en & weak_pullup_en)
    | (~drive_en & ~weak_pullup_en & float_reg);
endmodule : pcem_pin_model

// >>> include/pcem_pkg.sv
// Constants and carrier types for the port routing enables and match block.
// Assumes an 8-bit special function register space with register pages.
package pcem_pkg;
  // Register pages
  localparam logic [7:0] PCEM_PAGE_BASE = 8'h00;
  localparam logic [7:0] PCEM_PAGE_HIGH = 8'h0f;
  // Register addresses
  localparam logic [7:0] PCEM_ADDR_P0_MASK = 8'hc7;
  localparam logic [7:0] PCEM_ADDR_P0_MATCH = 8'hd7;
  localparam logic [7:0] PCEM_ADDR_P1_MASK = 8'hbf;
  localparam logic [7:0] PCEM_ADDR_P1_MATCH = 8'hcf;
  localparam logic [7:0] PCEM_ADDR_ROUTE2 = 8'he2;
  localparam logic [7:0] PCEM_ADDR_ROUTE3 = 8'he3;
  // Reset values
  localparam logic [7:0] PCEM_RST_MASK = 8'h00;
  localparam logic [7:0] PCEM_RST_MATCH = 8'hff;
  localparam logic [7:0] PCEM_RST_ROUTE2 = 8'h00;
  localparam logic [7:0] PCEM_RST_ROUTE3 = 8'h00;
  // Writable bits of the two routing registers
  localparam logic [7:0] PCEM_ROUTE2_WMASK = 8'h7f;
  localparam logic [7:0] PCEM_ROUTE3_WMASK = 8'hc0;
  // Field positions in the second routing register
  localparam int PCEM_SPI_EN_BIT = 6;
  localparam int PCEM_T1_EN_BIT = 5;
  localparam int PCEM_T0_EN_BIT = 4;
  localparam int PCEM_ECI_EN_BIT = 3;
  localparam int PCEM_CNT_LSB = 0;
  localparam int PCEM_CNT_W = 3;
  // Field positions in the third routing register
  localparam int PCEM_WPUD_BIT = 7;
  localparam int PCEM_ROUTING_MATRIX_ENABLE_BIT = 6;
  // Array pin count field
  localparam logic [2:0] PCEM_CNT_NONE = 3'h0;
  localparam logic [2:0] PCEM_CNT_RSVD = 3'h7;
  localparam int PCEM_CEX_NUM = 6;
  // Pins: port 0 at 0..7, port 1 at 8..15, port 2 at 16..22
  localparam int PCEM_PINS = 23;
  localparam int PCEM_IDX_W = 5;
  localparam int PCEM_PORT_W = 8;
  localparam logic [4:0] PCEM_SPI_PIN0 = 5'h10;
  // Walk order of the assigned functions
  localparam int PCEM_NFUNC = 9;
  localparam int PCEM_F_ECI = 6;
  localparam int PCEM_F_T0 = 7;
  localparam int PCEM_F_T1 = 8;
  // Register access request
  typedef struct packed {
    logic [7:0] page;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pcem_sfr_req_t;
  // One port compare setup
  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] pattern;
  } pcem_match_cfg_t;
endpackage : pcem_pkg

// >>> src/pcem_crossbar.sv
// Routing enables, pin assignment and port match for the I/O matrix.
// Assumes a paged register port and synchronous pin levels at clk.
// Functional notes
// - Second routing register top bit reads zero.
// - Second SPI enable routes clock, data pins.
// - SPI select pin only in four-wire mode.
// - Bit 5 routes timer 1 input.
// - Bit 4 routes timer 0 input.
// - Bit 3 routes array count input.
// - Pin count field routes modules cumulatively.
// - Pullups on unless disabled, analog or in reset.
// - Matrix treated disabled while enable zero.
// - Third register low six bits read zero.
// - Third register on two pages, second one.
// - Masked levels unequal pattern raise mismatch.
// - Compare actual pins whatever their routing.
// - Mask zero excludes pin from compare.
// - Pattern bit selects expected low or high.
// - Mismatch offered as interrupt and wake.
// - Output drivers off while matrix disabled.
// - Functions take lowest free unskipped pin.
`timescale 1ns/1ps
module pcem_crossbar #(
  parameter int NP = pcem_pkg::PCEM_PINS,
  parameter int NF = pcem_pkg::PCEM_NFUNC,
  parameter int IW = pcem_pkg::PCEM_IDX_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire pcem_pkg::pcem_sfr_req_t sfr_req,
  output logic sfr_hit,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic second_spi_four_wire,
  input wire logic [NP-1:0] pin_skip_bits,
  input wire logic [NP-1:0] pins_claimed_above,
  input wire logic [NP-1:0] pin_analog_mode,
  input wire logic [NP-1:0] port_pin_in,
  output logic [3:0] second_spi_pin_en,
  output logic [NF-1:0] func_pin_valid,
  output logic [NF-1:0][IW-1:0] func_pin_idx,
  output logic timer0_ext_in,
  output logic timer1_ext_in,
  output logic array_count_in,
  output logic port_output_allow,
  output logic [NP-1:0] weak_pullup_en,
  output logic mismatch_level,
  output logic mismatch_irq,
  output logic mismatch_wake
);
  localparam int CW = pcem_pkg::PCEM_CNT_W;
  localparam int CL = pcem_pkg::PCEM_CNT_LSB;
  localparam int NC = pcem_pkg::PCEM_CEX_NUM;

  // Cumulative module pin request for a count field
  function automatic logic [NC-1:0] cex_mask(input logic [CW-1:0] n);
    logic [NC-1:0] m;
    m = '0;
    if (n != pcem_pkg::PCEM_CNT_RSVD) begin
      for (int i = 0; i < NC; i++) begin
        if (i < int'(n)) begin
          m[i] = 1'b1;
        end
      end
    end
    return m;
  endfunction : cex_mask

  logic [7:0] p0_mask_reg;
  logic [7:0] p0_match_reg;
  logic [7:0] p1_mask_reg;
  logic [7:0] p1_match_reg;
  logic [7:0] route2_reg;
  logic [7:0] route3_reg;
  logic [7:0] sfr_rdata_reg;
  logic sfr_rvalid_reg;
  logic [3:0] spi_en_reg;
  logic [NF-1:0] func_ok_reg;
  logic [NF-1:0][IW-1:0] func_idx_reg;
  logic t0_in_reg;
  logic t1_in_reg;
  logic eci_in_reg;
  logic out_allow_reg;
  logic [NP-1:0] pullup_reg;

  // Address and page decode
  wire page_base = sfr_req.page == pcem_pkg::PCEM_PAGE_BASE;
  wire page_high = sfr_req.page == pcem_pkg::PCEM_PAGE_HIGH;
  wire sel_p0_mask = page_base &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_P0_MASK;
  wire sel_p0_match = page_base &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_P0_MATCH;
  wire sel_p1_mask = page_base &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_P1_MASK;
  wire sel_p1_match = page_base &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_P1_MATCH;
  wire sel_route2 = page_base &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_ROUTE2;
  wire sel_route3 = (page_base || page_high) &&
    sfr_req.addr == pcem_pkg::PCEM_ADDR_ROUTE3;
  wire any_sel = sel_p0_mask | sel_p0_match | sel_p1_mask |
    sel_p1_match | sel_route2 | sel_route3;
  assign sfr_hit = any_sel & (sfr_req.wr | sfr_req.rd);

  // Write values with unused bits forced to zero
  wire [7:0] route2_wval =
    sfr_req.wdata & pcem_pkg::PCEM_ROUTE2_WMASK;
  wire [7:0] route3_wval =
    sfr_req.wdata & pcem_pkg::PCEM_ROUTE3_WMASK;

  // Read selection
  wire [7:0] rd_val =
    sel_p0_mask ? p0_mask_reg :
    sel_p0_match ? p0_match_reg :
    sel_p1_mask ? p1_mask_reg :
    sel_p1_match ? p1_match_reg :
    sel_route2 ? route2_reg :
    sel_route3 ? route3_reg : 8'h00;

  // Register writes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      p0_mask_reg <= pcem_pkg::PCEM_RST_MASK;
      p0_match_reg <= pcem_pkg::PCEM_RST_MATCH;
      p1_mask_reg <= pcem_pkg::PCEM_RST_MASK;
      p1_match_reg <= pcem_pkg::PCEM_RST_MATCH;
      route2_reg <= pcem_pkg::PCEM_RST_ROUTE2;
      route3_reg <= pcem_pkg::PCEM_RST_ROUTE3;
    end else if (sfr_req.wr) begin
      if (sel_p0_mask) p0_mask_reg <= sfr_req.wdata;
      if (sel_p0_match) p0_match_reg <= sfr_req.wdata;
      if (sel_p1_mask) p1_mask_reg <= sfr_req.wdata;
      if (sel_p1_match) p1_match_reg <= sfr_req.wdata;
      if (sel_route2) route2_reg <= route2_wval;
      if (sel_route3) route3_reg <= route3_wval;
    end
  end

  // Registered read answer, unmapped reads return zero
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sfr_rdata_reg <= 8'h00;
      sfr_rvalid_reg <= 1'b0;
    end else begin
      sfr_rvalid_reg <= sfr_req.rd;
      if (sfr_req.rd) sfr_rdata_reg <= rd_val;
    end
  end
  assign sfr_rdata = sfr_rdata_reg;
  assign sfr_rvalid = sfr_rvalid_reg;

  // Field views
  wire xbar_on = route3_reg[pcem_pkg::PCEM_ROUTING_MATRIX_ENABLE_BIT];
  wire wpud = route3_reg[pcem_pkg::PCEM_WPUD_BIT];
  wire spi_on = xbar_on & route2_reg[pcem_pkg::PCEM_SPI_EN_BIT];
  wire [CW-1:0] cex_cnt = route2_reg[CL +: CW];

  // Fixed second SPI pins: select pin only in four-wire mode
  wire [3:0] spi_en_next =
    {spi_on & second_spi_four_wire, {3{spi_on}}};

  // Pins left for the walk: not skipped, not claimed, not SPI
  wire [NP-1:0] spi_claim =
    NP'({spi_en_next, 16'h0000});
  wire [NP-1:0] pin_avail =
    ~pin_skip_bits & ~pins_claimed_above & ~spi_claim;

  // Requests in walk order: modules, count input, timer 0, timer 1
  wire [NF-1:0] func_req = {
    route2_reg[pcem_pkg::PCEM_T1_EN_BIT],
    route2_reg[pcem_pkg::PCEM_T0_EN_BIT],
    route2_reg[pcem_pkg::PCEM_ECI_EN_BIT],
    cex_mask(cex_cnt)
  } & {NF{xbar_on}};

  wire [NF-1:0] func_ok;
  wire [NF-1:0][IW-1:0] func_idx;

  // Lowest free pin for each function
  pcem_pin_alloc #(
    .NF(NF),
    .NP(NP),
    .IW(IW)
  ) u_alloc (
    .func_req(func_req),
    .pin_avail(pin_avail),
    .func_ok(func_ok),
    .func_idx(func_idx)
  );

  // Input functions read their assigned pin, else low
  wire t0_next = func_ok_reg[pcem_pkg::PCEM_F_T0] &
    port_pin_in[func_idx_reg[pcem_pkg::PCEM_F_T0]];
  wire t1_next = func_ok_reg[pcem_pkg::PCEM_F_T1] &
    port_pin_in[func_idx_reg[pcem_pkg::PCEM_F_T1]];
  wire eci_next = func_ok_reg[pcem_pkg::PCEM_F_ECI] &
    port_pin_in[func_idx_reg[pcem_pkg::PCEM_F_ECI]];

  // Pullups unless globally disabled or pin is analog
  wire [NP-1:0] pullup_next =
    {NP{~wpud}} & ~pin_analog_mode;

  // Routing state registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      spi_en_reg <= 4'h0;
      func_ok_reg <= '0;
      func_idx_reg <= '0;
      out_allow_reg <= 1'b0;
      pullup_reg <= '0;
    end else begin
      spi_en_reg <= spi_en_next;
      func_ok_reg <= func_ok;
      func_idx_reg <= func_idx;
      out_allow_reg <= xbar_on;
      pullup_reg <= pullup_next;
    end
  end

  // Routed function inputs
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      t0_in_reg <= 1'b0;
      t1_in_reg <= 1'b0;
      eci_in_reg <= 1'b0;
    end else begin
      t0_in_reg <= t0_next;
      t1_in_reg <= t1_next;
      eci_in_reg <= eci_next;
    end
  end

  assign second_spi_pin_en = spi_en_reg;
  assign func_pin_valid = func_ok_reg;
  assign func_pin_idx = func_idx_reg;
  assign timer0_ext_in = t0_in_reg;
  assign timer1_ext_in = t1_in_reg;
  assign array_count_in = eci_in_reg;
  assign port_output_allow = out_allow_reg;
  assign weak_pullup_en = pullup_reg;

  // Port match on raw pin levels of ports 0 and 1
  pcem_pkg::pcem_match_cfg_t cfg0;
  pcem_pkg::pcem_match_cfg_t cfg1;
  assign cfg0 = '{mask: p0_mask_reg, pattern: p0_match_reg};
  assign cfg1 = '{mask: p1_mask_reg, pattern: p1_match_reg};
  logic mismatch;

  pcem_match_detect #(
    .W(pcem_pkg::PCEM_PORT_W)
  ) u_match (
    .clk(clk),
    .resetn(resetn),
    .pins(port_pin_in[15:0]),
    .cfg0(cfg0),
    .cfg1(cfg1),
    .mismatch(mismatch)
  );

  // Event offered to interrupt and wake logic
  assign mismatch_level = mismatch;
  assign mismatch_irq = mismatch;
  assign mismatch_wake = mismatch;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_rd_route2;
    sfr_req.rd && sel_route2;
  endsequence
  sequence s_rd_route3;
    sfr_req.rd && sel_route3;
  endsequence
  sequence s_wr_high_route3;
    sfr_req.wr && page_high &&
      sfr_req.addr == pcem_pkg::PCEM_ADDR_ROUTE3;
  endsequence

  a_route2_top_bit: assert property (
    s_rd_route2 |=> sfr_rvalid && !sfr_rdata[7])
    else $error("second routing top bit read as one");
  a_route3_low_bits: assert property (
    s_rd_route3 |=> sfr_rvalid && sfr_rdata[5:0] == 6'h00)
    else $error("third routing low bits not zero");
  a_route3_page_high: assert property (
    s_wr_high_route3 |=>
      route3_reg == ($past(sfr_req.wdata) & 8'hc0))
    else $error("third routing not written from page f");
  a_spi_pins: assert property (
    second_spi_pin_en[2:0] ==
      {3{$past(route2_reg[6] & route3_reg[6])}})
    else $error("second spi pins not following enable");
  a_spi_select: assert property (
    second_spi_pin_en[3] |->
      $past(second_spi_four_wire) && second_spi_pin_en[0])
    else $error("select pin routed outside four-wire mode");
  a_timer_gate: assert property (
    (!route2_reg[5] && !route2_reg[4]) [*3] |->
      !timer1_ext_in && !timer0_ext_in)
    else $error("timer input taken from pin while disabled");
  a_count_gate: assert property (
    !route2_reg[3] [*3] |-> !array_count_in)
    else $error("count input taken from pin while disabled");
  a_module_count: assert property (
    func_pin_valid[5:0] != 6'h00 |->
      $past(route2_reg[2:0] != 3'h0 && route2_reg[2:0] != 3'h7))
    else $error("module pins routed for empty or reserved count");
  a_pullup_off: assert property (
    $past(route3_reg[7]) |-> weak_pullup_en == '0)
    else $error("pullups left on while disabled");
  a_drivers_off: assert property (
    !route3_reg[6] [*2] |->
      !port_output_allow && func_pin_valid == '0 &&
      second_spi_pin_en == 4'h0)
    else $error("drivers or routing live with matrix off");
  // Compare from pins three clocks back, setup one clock back
  a_mismatch_level: assert property (
    $past(resetn, 3) && $past(resetn, 2) && $past(resetn) |->
      mismatch_level ==
      ((($past(port_pin_in[7:0], 3) & $past(p0_mask_reg)) !=
        ($past(p0_match_reg) & $past(p0_mask_reg))) ||
       (($past(port_pin_in[15:8], 3) & $past(p1_mask_reg)) !=
        ($past(p1_match_reg) & $past(p1_mask_reg)))))
    else $error("mismatch level disagrees with masked compare");

  // Routed inputs follow their assigned pin one clock later
  a_timer0_route: assert property (
    func_pin_valid[pcem_pkg::PCEM_F_T0] |=>
      timer0_ext_in == $past(port_pin_in[func_pin_idx[pcem_pkg::PCEM_F_T0]]))
    else $error("timer 0 input not taken from its pin");
  a_timer1_route: assert property (
    func_pin_valid[pcem_pkg::PCEM_F_T1] |=>
      timer1_ext_in == $past(port_pin_in[func_pin_idx[pcem_pkg::PCEM_F_T1]]))
    else $error("timer 1 input not taken from its pin");
  a_count_route: assert property (
    func_pin_valid[pcem_pkg::PCEM_F_ECI] |=>
      array_count_in == $past(port_pin_in[func_pin_idx[pcem_pkg::PCEM_F_ECI]]))
    else $error("count input not taken from its pin");

  // Drivers, pullups and page map follow the registers
  a_allow_on: assert property (
    route3_reg[pcem_pkg::PCEM_ROUTING_MATRIX_ENABLE_BIT] |=> port_output_allow)
    else $error("output drivers off with matrix on");
  a_pullup_on: assert property (
    $past(resetn) && !$past(route3_reg[pcem_pkg::PCEM_WPUD_BIT]) |->
      weak_pullup_en == ~$past(pin_analog_mode))
    else $error("pullups off on a digital pin");
  a_route2_page_only: assert property (
    sfr_req.wr && page_high &&
      sfr_req.addr == pcem_pkg::PCEM_ADDR_ROUTE2 |=> $stable(route2_reg))
    else $error("second routing written from page f");
endmodule : pcem_crossbar

// >>> src/pcem_match_detect.sv
// Synchronises two ports and compares masked levels with patterns.
// Assumes pin levels may change at any time relative to clk.
`timescale 1ns/1ps
module pcem_match_detect #(
  parameter int W = pcem_pkg::PCEM_PORT_W
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [2*W-1:0] pins,
  input wire pcem_pkg::pcem_match_cfg_t cfg0,
  input wire pcem_pkg::pcem_match_cfg_t cfg1,
  output logic mismatch
);
  logic [2*W-1:0] sync1_reg;
  logic [2*W-1:0] sync2_reg;
  logic mismatch_reg;
  wire [W-1:0] lvl0 = sync2_reg[W-1:0];
  wire [W-1:0] lvl1 = sync2_reg[2*W-1:W];
  wire miss0 = (lvl0 & cfg0.mask) != (cfg0.pattern & cfg0.mask);
  wire miss1 = (lvl1 & cfg1.mask) != (cfg1.pattern & cfg1.mask);
  wire mismatch_next = miss0 | miss1;

  // Two-stage synchroniser, then registered compare result
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      mismatch_reg <= 1'b0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      mismatch_reg <= mismatch_next;
    end
  end
  assign mismatch = mismatch_reg;
endmodule : pcem_match_detect

// >>> src/pcem_pin_alloc.sv
// Combinational pin walk for the priority-assigned functions.
// Assumes availability already excludes skipped and claimed pins.
`timescale 1ns/1ps
module pcem_pin_alloc #(
  parameter int NF = pcem_pkg::PCEM_NFUNC,
  parameter int NP = pcem_pkg::PCEM_PINS,
  parameter int IW = pcem_pkg::PCEM_IDX_W
) (
  input wire logic [NF-1:0] func_req,
  input wire logic [NP-1:0] pin_avail,
  output logic [NF-1:0] func_ok,
  output logic [NF-1:0][IW-1:0] func_idx
);
  // Each function in order takes the lowest free pin
  always_comb begin
    logic [NP-1:0] free;
    logic found;
    free = pin_avail;
    found = 1'b0;
    func_ok = '0;
    func_idx = '0;
    for (int f = 0; f < NF; f++) begin
      found = 1'b0;
      for (int p = 0; p < NP; p++) begin
        if (func_req[f] && free[p] && !found) begin
          found = 1'b1;
          free[p] = 1'b0;
          func_ok[f] = 1'b1;
          func_idx[f] = IW'(p);
        end
      end
    end
  end
endmodule : pcem_pin_alloc
